// file: src/smri_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the spi register block
// Assumes: 16-bit register words at internal addresses 0 to 5
// Notes:   included by bare name from the top module only
`ifndef SMRI_CFG_SVH
`define SMRI_CFG_SVH

`define SMRI_ADDR_RX        3'h0
`define SMRI_ADDR_TX        3'h1
`define SMRI_ADDR_STATUS    3'h2
`define SMRI_ADDR_CTRL      3'h3
`define SMRI_ADDR_RSVD      3'h4
`define SMRI_ADDR_MASK      3'h5

`define SMRI_BIT_ROE        3
`define SMRI_BIT_TOE        4
`define SMRI_BIT_EMPTY      5
`define SMRI_BIT_TRDY       6
`define SMRI_BIT_RRDY       7
`define SMRI_BIT_ERR        8
`define SMRI_BIT_SSO        10

`define SMRI_DATA_W         8
`define SMRI_FIFO_DEPTH     8
`define SMRI_IS_MASTER      1'b1

`define SMRI_CTRL_RESET     16'h0000
`define SMRI_MASK_RESET     16'h0000

`define SMRI_CLK_PERIOD_NS  40
`define SMRI_SCLK_PERIOD_NS 320
`define SMRI_HALF_CYCLES    (((`SMRI_SCLK_PERIOD_NS / 2) / `SMRI_CLK_PERIOD_NS) < 1 ? 1 : \
                             ((`SMRI_SCLK_PERIOD_NS / 2) / `SMRI_CLK_PERIOD_NS))

`endif

// file: src/smri_pkg.sv
// Purpose: shared types of the spi register block
// Assumes: constants live in smri_cfg.svh
// Notes:   nothing is imported; users write smri_pkg::name
package smri_pkg;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [2:0]  addr;
      logic [15:0] wdata;
   } smri_bus_req_t;

   typedef enum logic [1:0] {
      SMRI_IDLE  = 2'b01,
      SMRI_SHIFT = 2'b10
   } smri_state_t;

endpackage

// file: src/smri_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are levels from outside the clk domain
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module smri_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule
`default_nettype wire

// file: src/smri_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock; depth a power of two
// Notes:   full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ns
`default_nettype none
module smri_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;

   assign out_valid = (wr_ptr != rd_ptr);
   assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: src/smri_top.sv
// Purpose: register face of an spi master with a small shift engine behind it
// Assumes: single clock clk at 25 MHz; miso is a pin and is synchronised
// Notes:   mode 0, msb first; transmit words queue in an 8-word fifo
`timescale 1ns/1ns
`default_nettype none
`include "smri_cfg.svh"

// Behaviour
// - six 16-bit registers at addresses 0 to 5
// - data words sit in low bits
// - any status write clears both overruns and error, unless a receive overrun lands in the same cycle
// - select override and mask exist in master build
// - undefined bits read zero, writes ignored
// - completed word loads receive register, sets ready
// - reading receive register clears receive ready
// - writes to receive register are ignored
// - every new word loads, read or not
// - load while ready sets receive overrun
// - mask bit k drives select output k
// - status bits three to eight as mapped
// - error flag is OR of both overruns
// - transmit ready drops only while the 8-word fifo is full
// - interrupt when flag and its enable both set
module smri_top (
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire smri_pkg::smri_bus_req_t bus_req,
   output logic                  [15:0] rd_data,
   output logic                         irq,
   output logic                         sclk,
   output logic                         mosi,
   input  wire logic                    miso,
   output logic                  [15:0] target_sel_n
);
   localparam int N = `SMRI_DATA_W;
   localparam int HW = $clog2(`SMRI_HALF_CYCLES + 1);
   localparam int CW = $clog2(N + 1);

   logic [N-1:0]   receive_word;
   logic [15:0]    interrupt_and_select_control;
   logic [15:0]    target_select_mask;
   logic           roe;
   logic           toe;
   logic           rrdy;
   logic           err_flag;
   logic           trdy;
   logic           shifter_empty_flag;

   logic [HW-1:0]  div_cnt;
   logic           half_tick;
   smri_pkg::smri_state_t state;
   logic [N-1:0]   tx_shift;
   logic [N-1:0]   rx_shift;
   logic [CW-1:0]  bit_cnt;
   logic           rx_done;
   logic [N-1:0]   next_rx_word;
   logic           miso_s;

   logic           fifo_out_valid;
   logic           fifo_out_ready;
   logic [N-1:0]   fifo_out_data;
   logic           tx_push;

   logic           wr_rx;
   logic           wr_tx;
   logic           wr_status;
   logic           wr_ctrl;
   logic           wr_mask;
   logic           rd_rx;

   // bus decode; addresses 4, 6 and 7 take writes with no effect
   assign wr_rx     = bus_req.wr && (bus_req.addr == `SMRI_ADDR_RX);
   assign wr_tx     = bus_req.wr && (bus_req.addr == `SMRI_ADDR_TX);
   assign wr_status = bus_req.wr && (bus_req.addr == `SMRI_ADDR_STATUS);
   assign wr_ctrl   = bus_req.wr && (bus_req.addr == `SMRI_ADDR_CTRL);
   assign wr_mask   = bus_req.wr && (bus_req.addr == `SMRI_ADDR_MASK) && `SMRI_IS_MASTER;
   assign rd_rx     = bus_req.rd && (bus_req.addr == `SMRI_ADDR_RX);

   smri_sync #(
      .W (1)
   ) u_miso_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (miso),
      .dout   (miso_s)
   );

   // a full fifo refuses the word; that refusal is the transmit overrun
   assign tx_push = wr_tx;
   assign fifo_out_ready = (state == smri_pkg::SMRI_IDLE);

   smri_fifo #(
      .W (N),
      .D (`SMRI_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (tx_push),
      .in_ready  (trdy),
      .in_data   (bus_req.wdata[N-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // sclk half-period enable from the divider
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= '0;
      end else if (state != smri_pkg::SMRI_SHIFT || half_tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign half_tick = (state == smri_pkg::SMRI_SHIFT) &&
                      (div_cnt == HW'(`SMRI_HALF_CYCLES - 1));

   // shift engine: sample on rising sclk, change on falling sclk
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= smri_pkg::SMRI_IDLE;
         sclk     <= 1'b0;
         mosi     <= 1'b0;
         tx_shift <= '0;
         rx_shift <= '0;
         bit_cnt  <= '0;
         rx_done  <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         case (state)
            smri_pkg::SMRI_IDLE: begin
               sclk <= 1'b0;
               if (fifo_out_valid) begin
                  tx_shift <= {fifo_out_data[N-2:0], 1'b0};
                  mosi     <= fifo_out_data[N-1];
                  bit_cnt  <= '0;
                  state    <= smri_pkg::SMRI_SHIFT;
               end
            end
            smri_pkg::SMRI_SHIFT: begin
               if (half_tick) begin
                  if (!sclk) begin
                     sclk     <= 1'b1;
                     rx_shift <= {rx_shift[N-2:0], miso_s};
                     bit_cnt  <= bit_cnt + 1'b1;
                  end else begin
                     sclk <= 1'b0;
                     if (bit_cnt == CW'(N)) begin
                        rx_done <= 1'b1;
                        state   <= smri_pkg::SMRI_IDLE;
                     end else begin
                        mosi     <= tx_shift[N-1];
                        tx_shift <= {tx_shift[N-2:0], 1'b0};
                     end
                  end
               end
            end
            default: begin
               state <= smri_pkg::SMRI_IDLE;
               sclk  <= 1'b0;
            end
         endcase
      end
   end

   assign next_rx_word = rx_shift;

   // every finished word loads, read or not
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         receive_word <= '0;
      end else if (rx_done) begin
         receive_word <= next_rx_word;
      end
   end

   // receive ready: the new word wins over a read in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rrdy <= 1'b0;
      end else if (rx_done) begin
         rrdy <= 1'b1;
      end else if (rd_rx) begin
         rrdy <= 1'b0;
      end
   end

   // overrun flags; a new event beats a status write in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         roe <= 1'b0;
         toe <= 1'b0;
      end else begin
         if (rx_done && rrdy) begin
            roe <= 1'b1;
         end else if (wr_status) begin
            roe <= 1'b0;
         end
         if (wr_tx && !trdy) begin
            toe <= 1'b1;
         end else if (wr_status) begin
            toe <= 1'b0;
         end
      end
   end

   assign err_flag = roe | toe;
   assign shifter_empty_flag = (state == smri_pkg::SMRI_IDLE) && !fifo_out_valid;

   // control and mask; wr_rx deliberately touches nothing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         interrupt_and_select_control <= `SMRI_CTRL_RESET;
         target_select_mask           <= `SMRI_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            interrupt_and_select_control <= bus_req.wdata & {5'h00, `SMRI_IS_MASTER, 10'h1d8};
         end
         if (wr_mask) begin
            target_select_mask <= bus_req.wdata;
         end
      end
   end

   // select k is low when mask bit k is set and override or a word is active
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         target_sel_n <= 16'hffff;
      end else if (interrupt_and_select_control[`SMRI_BIT_SSO] ||
                   state == smri_pkg::SMRI_SHIFT) begin
         target_sel_n <= ~target_select_mask;
      end else begin
         target_sel_n <= 16'hffff;
      end
   end

   // interrupt enables share the bit positions of their status flags
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (roe      & interrupt_and_select_control[`SMRI_BIT_ROE])  |
                (toe      & interrupt_and_select_control[`SMRI_BIT_TOE])  |
                (trdy     & interrupt_and_select_control[`SMRI_BIT_TRDY]) |
                (rrdy     & interrupt_and_select_control[`SMRI_BIT_RRDY]) |
                (err_flag & interrupt_and_select_control[`SMRI_BIT_ERR]);
      end
   end

   // registered read answer; undefined bits read as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= 16'h0000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            `SMRI_ADDR_RX:     rd_data <= {{(16-N){1'b0}}, receive_word};
            `SMRI_ADDR_STATUS: rd_data <= {7'h00, err_flag, rrdy, trdy,
                                          shifter_empty_flag, toe, roe, 3'h0};
            `SMRI_ADDR_CTRL:   rd_data <= interrupt_and_select_control;
            `SMRI_ADDR_MASK:   rd_data <= target_select_mask;
            default:           rd_data <= 16'h0000;
         endcase
      end
   end

   a_status_clear: assert property (@(posedge clk) disable iff (!arst_n)
      wr_status && !rx_done && trdy |=> !roe && !toe)
      else $error("status write did not clear overruns");

   a_err_or_read: assert property (@(posedge clk) disable iff (!arst_n)
      bus_req.rd && bus_req.addr == `SMRI_ADDR_STATUS
      |=> rd_data[`SMRI_BIT_ERR] == (rd_data[`SMRI_BIT_ROE] | rd_data[`SMRI_BIT_TOE]))
      else $error("error bit is not or of overruns");

   a_rx_load: assert property (@(posedge clk) disable iff (!arst_n)
      rx_done |=> rrdy && receive_word == $past(rx_shift))
      else $error("finished word not loaded");

   a_rx_overrun: assert property (@(posedge clk) disable iff (!arst_n)
      rx_done && rrdy |=> roe)
      else $error("overrun not flagged");

   a_rx_read_clear: assert property (@(posedge clk) disable iff (!arst_n)
      rd_rx && !rx_done |=> !rrdy)
      else $error("read did not clear receive ready");

   a_rx_write_ignored: assert property (@(posedge clk) disable iff (!arst_n)
      wr_rx && !rx_done |=> $stable(receive_word) && $stable(rrdy) && $stable(roe))
      else $error("write to receive register had effect");

   a_tx_overrun: assert property (@(posedge clk) disable iff (!arst_n)
      wr_tx && !trdy |=> toe)
      else $error("write while full not flagged");

   a_irq_cause: assert property (@(posedge clk) disable iff (!arst_n)
      rrdy && interrupt_and_select_control[`SMRI_BIT_RRDY] |=> irq)
      else $error("interrupt missing for enabled flag");

   a_select_mask: assert property (@(posedge clk) disable iff (!arst_n)
      interrupt_and_select_control[`SMRI_BIT_SSO]
      |=> target_sel_n == ~$past(target_select_mask))
      else $error("select outputs do not follow mask");

endmodule
`default_nettype wire

// file: verification/smri_spi_slave.sv
// Purpose: behavioural spi slave on the far side of the register block
// Assumes: mode 0, msb first, 8-bit words
// Notes:   miso shows the inverse of its last value while deselected
`timescale 1ns/1ns
`default_nettype none
module smri_spi_slave (
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic [7:0] reply,
   output logic            miso,
   output logic      [7:0] got,
   output int              words
);
   logic [7:0] rx;
   logic [7:0] sh;
   int         nbit;

   initial begin
      miso = 1'b0;
      got = 8'h00;
      words = 0;
      nbit = 0;
   end
   always @(negedge sel_n) begin
      sh = reply;
      miso = reply[7];
      nbit = 0;
   end
   // no pull on the line, so a released miso must not look valid
   always @(posedge sel_n) begin
      miso = ~miso;
   end
   always @(posedge sclk) begin
      if (!sel_n) begin
         rx = {rx[6:0], mosi};
         nbit++;
         if (nbit == 8) begin
            got = rx;
            words++;
            nbit = 0;
         end
      end
   end
   // reload at the last fall so a held select can run words back to back
   always @(negedge sclk) begin
      if (!sel_n) begin
         sh = (nbit == 0) ? reply : {sh[6:0], 1'b0};
         miso = sh[7];
      end
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: self-checking bench of the spi register block
// Assumes: 25 MHz clk, width 8, master build
// Notes:   random data from a fixed seed, corner cases in between
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                    clk;
   logic                    arst_n;
   smri_pkg::smri_bus_req_t bus_req;
   logic             [15:0] rd_data;
   logic                    irq;
   logic                    sclk;
   logic                    mosi;
   logic                    miso;
   logic             [15:0] target_sel_n;
   logic              [3:0] sel_idx;
   logic              [7:0] reply;
   logic              [7:0] got;
   int                      words;
   int                      miscompares;
   int                      checks;
   int                      seed;
   int                      n0;
   logic             [15:0] v;
   logic             [15:0] m;
   logic             [15:0] ctl;
   logic              [7:0] tx;
   logic              [7:0] r8;

   smri_top uut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
                 .sclk(sclk), .mosi(mosi), .miso(miso), .target_sel_n(target_sel_n));
   smri_spi_slave peer (.sclk(sclk), .mosi(mosi), .sel_n(target_sel_n[sel_idx]), .reply(reply),
                        .miso(miso), .got(got), .words(words));

   always #20 clk = ~clk;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // control keeps only the enables and the override
   function automatic logic [15:0] ctrl_kept(input logic [15:0] w);
      return w & 16'h05d8;
   endfunction
   function automatic logic [15:0] sel_low(input logic [3:0] k);
      return ~(16'h0001 << k);
   endfunction
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // strobes are left standing; the next call replaces them in one assignment
   task automatic bus_op(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
      bus_req = '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk);
      #1;
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
      bus_op(1'b1, 1'b0, a, d);
      bus_op(1'b0, 1'b0, a, 16'h0000);
   endtask
   task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
      bus_op(1'b0, 1'b1, a, 16'h0000);
      bus_op(1'b0, 1'b0, a, 16'h0000);
      d = rd_data;
   endtask
   task automatic wait_status(input logic [15:0] bits);
      logic [15:0] s;
      int          n;
      n = 0;
      reg_rd(3'h2, s);
      while ((s & bits) !== bits && n < 600) begin
         reg_rd(3'h2, s);
         n++;
      end
      check("status wait", s & bits, bits);
   endtask
   task automatic send_word(input logic [3:0] k, input logic [7:0] t, input logic [7:0] r);
      int n;
      sel_idx = k;
      reply = r;
      reg_wr(3'h1, {8'h00, t});
      n = 0;
      while (target_sel_n === 16'hffff && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("select", target_sel_n, sel_low(k));
      // ready may already stand from an unread word, so wait for the shifter too
      wait_status(16'h00a0);
      check("mosi byte", {8'h00, got}, {8'h00, t});
   endtask

   initial begin
      #(60000 * 40);
      miscompares++;
      end_of_test();
   end

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      bus_req = '0;
      sel_idx = 4'h0;
      reply = 8'h00;
      miscompares = 0;
      checks = 0;
      seed = 32'hb35b;
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'b1;
      check("reset irq", {15'h0000, irq}, 16'h0000);
      check("reset select", target_sel_n, 16'hffff);
      for (int a = 2; a < 8; a++) begin
         reg_rd(a[2:0], v);
         check("reset read", v, (a == 2) ? 16'h0060 : 16'h0000);
      end
      $display("test reset done");

      ctl = 16'($random(seed));
      m = 16'($random(seed));
      reg_wr(3'h3, ctl);
      reg_wr(3'h5, m);
      reg_rd(3'h3, v);
      check("control", v, ctrl_kept(ctl));
      reg_rd(3'h5, v);
      check("mask", v, m);
      reg_wr(3'h4, 16'($random(seed)));
      reg_rd(3'h4, v);
      check("reserved", v, 16'h0000);
      reg_rd(3'h3, v);
      check("control kept", v, ctrl_kept(ctl));
      check("trdy irq", {15'h0000, irq}, {15'h0000, ctl[6]});
      check("override", target_sel_n, ctl[10] ? ~m : 16'hffff);
      reg_wr(3'h3, 16'h0000);
      $display("test registers done");

      for (int k = 0; k < 16; k++) begin
         tx = 8'($random(seed));
         r8 = 8'($random(seed));
         reg_wr(3'h5, 16'h0001 << k);
         send_word(k[3:0], tx, r8);
         reg_wr(3'h0, 16'($random(seed)));
         reg_rd(3'h2, v);
         check("rrdy kept", v & 16'h0098, 16'h0080);
         reg_rd(3'h0, v);
         check("rx word", v, {8'h00, r8});
         reg_rd(3'h2, v);
         check("rrdy clear", v & 16'h0080, 16'h0000);
      end
      $display("test receive done");

      // byte command with select held: only valid for widths of eight or less
      reply = 8'h96;
      sel_idx = 4'h0;
      reg_wr(3'h5, 16'h0001);
      reg_wr(3'h3, 16'h0400);
      repeat (2) bus_op(1'b0, 1'b0, 3'h0, 16'h0000);
      check("held select", target_sel_n, 16'hfffe);
      send_word(4'h0, 8'h9f, 8'h96);
      reg_rd(3'h0, v);
      send_word(4'h0, 8'h00, 8'h96);
      reg_rd(3'h0, v);
      check("read phase", v, 16'h0096);
      reg_wr(3'h3, 16'h0000);
      repeat (2) bus_op(1'b0, 1'b0, 3'h0, 16'h0000);
      check("release", target_sel_n, 16'hffff);
      $display("test command done");

      reg_wr(3'h5, 16'h8000);
      reg_wr(3'h3, 16'h0100);
      send_word(4'hf, 8'h5a, 8'ha5);
      send_word(4'hf, 8'hc3, 8'h3c);
      reg_rd(3'h2, v);
      check("overrun", v & 16'h0198, 16'h0188);
      check("err irq", {15'h0000, irq}, 16'h0001);
      reg_wr(3'h2, 16'($random(seed)));
      reg_rd(3'h2, v);
      check("status clear", v & 16'h0198, 16'h0080);
      check("irq clear", {15'h0000, irq}, 16'h0000);
      $display("test overrun done");

      reg_wr(3'h3, 16'h0000);
      reg_rd(3'h0, v);
      n0 = words;
      // back to back, so the queue overflows before the first word ends
      for (int i = 0; i < 12; i++) begin
         bus_op(1'b1, 1'b0, 3'h1, {8'h00, 8'($random(seed))});
      end
      bus_op(1'b0, 1'b0, 3'h0, 16'h0000);
      reg_rd(3'h2, v);
      check("fifo full", v & 16'h01f8, 16'h0110);
      wait_status(16'h0020);
      reg_rd(3'h2, v);
      check("drained", v & 16'h0060, 16'h0060);
      check("words sent", 16'(words - n0), 16'h0009);
      $display("test fifo done");
      end_of_test();
   end
endmodule
`default_nettype wire
